/* design/mdr_pkg.sv */
// Constants and types for the serial register map block
package mdr_pkg;
	// Input register space
	localparam logic [15:0] IN_LAST       = 16'h000d;
	localparam logic [3:0]  IN_FAULT      = 4'ha;
	localparam logic [3:0]  IN_TERMINALS  = 4'hd;
	// Holding register space
	localparam logic [15:0] PARAM_LAST    = 16'h00ff;
	localparam int          PARAM_COUNT   = 256;
	localparam logic [15:0] COMM_BASE     = 16'h0200;
	localparam logic [15:0] MAIN_CMD      = 16'h0200;
	localparam logic [15:0] FREQ_REF      = 16'h0201;
	localparam logic [15:0] VIN_LO        = 16'h0202;
	localparam logic [15:0] VIN_HI        = 16'h0203;
	localparam logic [15:0] DOUT          = 16'h0204;
	localparam logic [15:0] AOUT          = 16'h0205;
	localparam logic [15:0] RSV_FIRST     = 16'h0206;
	localparam logic [15:0] RSV_LAST      = 16'h020f;
	localparam logic [15:0] STATUS        = 16'h0210;
	localparam logic [15:0] TERMINALS     = 16'h0211;
	localparam logic [15:0] VOUT_LO       = 16'h0212;
	localparam logic [15:0] VOUT_HI       = 16'h0213;
	localparam logic [15:0] MIRROR_FIRST  = 16'h0220;
	localparam logic [15:0] MIRROR_LAST   = 16'h022d;
	localparam logic [15:0] AIN_ONE       = 16'h022e;
	localparam logic [15:0] AIN_TWO       = 16'h022f;
	localparam logic [15:0] PULSE_IN      = 16'h0230;
	localparam logic [15:0] COMM_LAST     = 16'h023f;
	// Command coils
	localparam logic [15:0] COIL_FIRST    = 16'h0048;
	localparam logic [15:0] COIL_LAST     = 16'h004f;
	localparam logic [15:0] COIL_ON       = 16'hff00;
	localparam logic [15:0] COIL_OFF      = 16'h0000;
	// Bit positions
	localparam int          RELAY_DOUT_BIT = 3;
	localparam int          VIN_EN_BIT     = 8;
	// Function and exception codes
	localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
	localparam logic [7:0]  FC_RD_IN      = 8'h04;
	localparam logic [7:0]  FC_WR_COIL    = 8'h05;
	localparam logic [7:0]  FC_WR_ONE     = 8'h06;
	localparam logic [7:0]  FC_WR_MULTI   = 8'h10;
	localparam logic [7:0]  EXC_FLAG      = 8'h80;
	localparam logic [7:0]  EX_FUNC       = 8'h01;
	localparam logic [7:0]  EX_ADDR       = 8'h02;
	localparam logic [7:0]  EX_VALUE      = 8'h03;
	localparam logic [15:0] MAX_WORDS     = 16'h0014;
	// Frame check
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'ha001;
	// Parameter slots and the value selecting the serial port
	localparam logic [7:0]  PAR_CMD_SRC   = 8'h01;
	localparam logic [7:0]  PAR_FREQ_SRC  = 8'h02;
	localparam logic [15:0] SRC_COMM      = 16'h0002;
	// Fault code bases by fault kind, kind 0 means no fault
	localparam logic [7:0]  FAULT_BASE [8] = '{8'h00, 8'h40, 8'h50, 8'h58,
		8'h5c, 8'h60, 8'h64, 8'h68};
	localparam int          BUF_DEPTH     = 64;
	localparam logic [6:0]  MIN_FRAME     = 7'h04;
	localparam logic [6:0]  STD_FRAME     = 7'h08;
	localparam logic [6:0]  MULTI_HDR     = 7'h09;
	localparam logic [6:0]  WR_RESP_LEN   = 7'h06;
	localparam logic [6:0]  EXC_RESP_LEN  = 7'h03;

	typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_CHECK, ST_EXEC, ST_SEND} mdr_state_t;
endpackage

/* design/mdr_register_map.sv */
// Serial slave register map: frame check, decode, registers and response
`timescale 1ns/100ps
module mdr_register_map
	import mdr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  slave_address,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	input  wire logic        rx_frame_end,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic             tx_last,
	input  wire logic [15:0] meas_word [12],
	input  wire logic [2:0]  fault_kind,
	input  wire logic [1:0]  fault_suffix,
	input  wire logic [5:0]  discrete_inputs_one_to_six,
	input  wire logic [15:0] status_coils,
	input  wire logic        relay_state,
	input  wire logic [15:0] virtual_outputs_low,
	input  wire logic [15:0] virtual_outputs_high,
	input  wire logic [15:0] analog_input_one_value,
	input  wire logic [15:0] analog_input_two_value,
	input  wire logic [15:0] pulse_input_value,
	output logic      [7:0]  command_coils,
	output logic             run_command,
	output logic             virtual_inputs_enabled,
	output logic      [15:0] comm_frequency_reference,
	output logic             freq_ref_from_comm,
	output logic      [15:0] virtual_inputs_low,
	output logic      [15:0] virtual_inputs_high,
	output logic             changeover_relay_output,
	output logic      [15:0] analog_output_terminal,
	output logic             param_nv_write,
	output logic      [7:0]  param_nv_index,
	output logic      [15:0] param_nv_data
);
	import mdr_pkg::*;

	mdr_state_t  state_ff;
	logic [7:0]  buf_ff [BUF_DEPTH];
	logic [6:0]  rx_len_ff;
	logic        ovf_ff;
	logic [15:0] crc_ff;
	logic [15:0] start_ff;
	logic [4:0]  cnt_ff;
	logic [4:0]  idx_ff;
	logic        bcast_ff;
	logic [6:0]  resp_len_ff;
	logic [6:0]  sidx_ff;
	logic [7:0]  tx_data_ff;
	logic [15:0] param_ff [PARAM_COUNT];
	logic [8:0]  main_cmd_ff;
	logic [15:0] freq_ff;
	logic [15:8] vin_lo_ff;
	logic [15:0] vin_hi_ff;
	logic [15:0] dout_ff;
	logic [15:0] aout_ff;
	logic        nv_wr_ff;
	logic [7:0]  nv_idx_ff;
	logic [15:0] nv_data_ff;
	logic [15:0] start_w;
	logic [15:0] cnt_w;
	logic [15:0] n_eff;
	logic [16:0] last_w;
	logic        range_ok;
	logic        n_ok;
	logic [7:0]  exc;
	logic        frame_ok;
	logic        exec_last;
	logic        is_read;
	logic [15:0] rd_addr;
	logic [15:0] rd_data;
	logic [15:0] in_data;
	logic [7:0]  fault_code;
	logic        wr_en;
	logic        coil_en;
	logic [15:0] wr_data;
	logic [5:0]  rd_ptr;
	logic [15:0] crc_n;
	logic [6:0]  nidx;
	logic        cmd_src_comm;

	// One byte of the reflected CRC16, one bit per step
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int j = 0; j < 8; j++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Request fields and validity checks
	assign start_w  = {buf_ff[2], buf_ff[3]};
	assign cnt_w    = {buf_ff[4], buf_ff[5]};
	assign n_eff    = (buf_ff[1] == FC_WR_ONE) ? 16'h0001 : cnt_w;
	assign last_w   = {1'b0, start_w} + {1'b0, n_eff} - 17'h00001;
	assign n_ok     = (cnt_w != 16'h0000) && (cnt_w <= MAX_WORDS);
	assign frame_ok = (crc_ff == 16'h0000) && (rx_len_ff >= MIN_FRAME) && !ovf_ff;
	assign range_ok = (buf_ff[1] == FC_RD_IN) ? (last_w <= {1'b0, IN_LAST}) :
		((last_w <= {1'b0, PARAM_LAST}) ||
		(start_w >= COMM_BASE && last_w <= {1'b0, COMM_LAST}));

	// Exception code of the request, zero when it is acceptable
	always_comb begin
		exc = 8'h00;
		case (buf_ff[1])
			FC_RD_HOLD, FC_RD_IN: begin
				if (rx_len_ff != STD_FRAME || !n_ok) exc = EX_VALUE;
				else if (!range_ok) exc = EX_ADDR;
			end
			FC_WR_ONE: begin
				if (rx_len_ff != STD_FRAME) exc = EX_VALUE;
				else if (!range_ok) exc = EX_ADDR;
			end
			FC_WR_MULTI: begin
				if (!n_ok || buf_ff[6] != {cnt_w[6:0], 1'b0} ||
					rx_len_ff != MULTI_HDR + {cnt_w[5:0], 1'b0}) exc = EX_VALUE;
				else if (!range_ok) exc = EX_ADDR;
			end
			FC_WR_COIL: begin
				if (rx_len_ff != STD_FRAME) exc = EX_VALUE;
				else if (start_w < COIL_FIRST || start_w > COIL_LAST) exc = EX_ADDR;
				else if (cnt_w != COIL_ON && cnt_w != COIL_OFF) exc = EX_VALUE;
			end
			default: exc = EX_FUNC;
		endcase
	end

	// Fault code and input register selection
	assign fault_code = FAULT_BASE[fault_kind] + {6'h00, fault_suffix};
	always_comb begin
		in_data = 16'h0000;
		case (rd_addr[3:0])
			IN_FAULT:     in_data = (fault_kind == 3'h0) ? 16'h0000 : {8'h00, fault_code};
			IN_TERMINALS: in_data = {10'h000, discrete_inputs_one_to_six};
			4'hb, 4'hc:   in_data = meas_word[rd_addr[3:0] - 4'h1];
			4'he, 4'hf:   in_data = 16'h0000;
			default:      in_data = meas_word[rd_addr[3:0]];
		endcase
	end

	// Read data for the word being fetched
	assign rd_addr = start_ff + {11'h000, idx_ff};
	always_comb begin
		rd_data = 16'h0000;
		if (buf_ff[1] == FC_RD_IN) rd_data = in_data;
		else if (rd_addr <= PARAM_LAST) rd_data = param_ff[rd_addr[7:0]];
		else begin
			case (rd_addr)
				MAIN_CMD:  rd_data = {7'h00, main_cmd_ff};
				FREQ_REF:  rd_data = freq_ff;
				VIN_LO:    rd_data = virtual_inputs_low;
				VIN_HI:    rd_data = vin_hi_ff;
				DOUT:      rd_data = dout_ff;
				AOUT:      rd_data = aout_ff;
				STATUS:    rd_data = status_coils;
				TERMINALS: rd_data = {4'h0, relay_state, 5'h00, discrete_inputs_one_to_six};
				VOUT_LO:   rd_data = virtual_outputs_low;
				VOUT_HI:   rd_data = virtual_outputs_high;
				AIN_ONE:   rd_data = analog_input_one_value;
				AIN_TWO:   rd_data = analog_input_two_value;
				PULSE_IN:  rd_data = pulse_input_value;
				default: begin
					if (rd_addr >= MIRROR_FIRST && rd_addr <= MIRROR_LAST) rd_data = in_data;
					else rd_data = 16'h0000;
				end
			endcase
		end
	end

	// Execute-phase strobes
	assign is_read   = (buf_ff[1] == FC_RD_HOLD) || (buf_ff[1] == FC_RD_IN);
	assign exec_last = (idx_ff == cnt_ff - 5'h01);
	assign wr_en     = (state_ff == ST_EXEC) && (buf_ff[1] == FC_WR_ONE || buf_ff[1] == FC_WR_MULTI);
	assign coil_en   = (state_ff == ST_EXEC) && (buf_ff[1] == FC_WR_COIL);
	assign rd_ptr    = {idx_ff, 1'b0} + 6'h07;
	assign wr_data   = (buf_ff[1] == FC_WR_MULTI) ? {buf_ff[rd_ptr], buf_ff[rd_ptr + 6'h01]} : cnt_w;

	// Transmit sequencing
	assign crc_n    = (sidx_ff < resp_len_ff) ? crc_upd(crc_ff, tx_data_ff) : crc_ff;
	assign nidx     = sidx_ff + 7'h01;
	assign tx_data  = tx_data_ff;
	assign tx_valid = (state_ff == ST_SEND);
	assign tx_last  = tx_valid && (sidx_ff == resp_len_ff + 7'h01);

	// Frame receive, check, execute and send
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff    <= ST_IDLE;
			rx_len_ff   <= 7'h00;
			ovf_ff      <= 1'b0;
			crc_ff      <= CRC_INIT;
			start_ff    <= 16'h0000;
			cnt_ff      <= 5'h00;
			idx_ff      <= 5'h00;
			bcast_ff    <= 1'b0;
			resp_len_ff <= 7'h00;
			sidx_ff     <= 7'h00;
			tx_data_ff  <= 8'h00;
			for (int i = 0; i < BUF_DEPTH; i++) buf_ff[i] <= 8'h00;
		end else begin
			unique case (state_ff)
				ST_IDLE, ST_RECV: begin
					if (rx_valid) begin
						state_ff <= ST_RECV;
						crc_ff   <= crc_upd(crc_ff, rx_data);
						if (rx_len_ff == 7'(BUF_DEPTH)) ovf_ff <= 1'b1;
						else begin
							buf_ff[rx_len_ff[5:0]] <= rx_data;
							rx_len_ff              <= rx_len_ff + 7'h01;
						end
					end else if (rx_frame_end && state_ff == ST_RECV) state_ff <= ST_CHECK;
				end
				ST_CHECK: begin
					start_ff <= start_w;
					cnt_ff   <= (buf_ff[1] == FC_WR_MULTI || buf_ff[1] == FC_RD_HOLD ||
						buf_ff[1] == FC_RD_IN) ? cnt_w[4:0] : 5'h01;
					idx_ff   <= 5'h00;
					bcast_ff <= (buf_ff[0] == 8'h00);
					if (!frame_ok || slave_address == 8'h00 ||
						(buf_ff[0] != slave_address && buf_ff[0] != 8'h00)) begin
						state_ff  <= ST_IDLE;
						rx_len_ff <= 7'h00;
						ovf_ff    <= 1'b0;
						crc_ff    <= CRC_INIT;
					end else if (exc != 8'h00) begin
						buf_ff[1]   <= buf_ff[1] | EXC_FLAG;
						buf_ff[2]   <= exc;
						resp_len_ff <= EXC_RESP_LEN;
						state_ff    <= (buf_ff[0] == 8'h00) ? ST_IDLE : ST_SEND;
						sidx_ff     <= 7'h00;
						tx_data_ff  <= buf_ff[0];
						crc_ff      <= CRC_INIT;
						rx_len_ff   <= 7'h00;
						ovf_ff      <= 1'b0;
					end else state_ff <= ST_EXEC;
				end
				ST_EXEC: begin
					idx_ff <= idx_ff + 5'h01;
					if (is_read) begin
						buf_ff[rd_ptr - 6'h04] <= rd_data[15:8];
						buf_ff[rd_ptr - 6'h03] <= rd_data[7:0];
					end
					if (exec_last) begin
						if (is_read) begin
							buf_ff[2]   <= {2'b00, cnt_ff, 1'b0};
							resp_len_ff <= EXC_RESP_LEN + {1'b0, cnt_ff, 1'b0};
						end else resp_len_ff <= WR_RESP_LEN;
						state_ff   <= bcast_ff ? ST_IDLE : ST_SEND;
						sidx_ff    <= 7'h00;
						tx_data_ff <= buf_ff[0];
						crc_ff     <= CRC_INIT;
						rx_len_ff  <= 7'h00;
						ovf_ff     <= 1'b0;
					end
				end
				ST_SEND: begin
					if (tx_ready) begin
						crc_ff  <= crc_n;
						sidx_ff <= nidx;
						if (nidx < resp_len_ff) tx_data_ff <= buf_ff[nidx[5:0]];
						else if (nidx == resp_len_ff) tx_data_ff <= crc_n[7:0];
						else tx_data_ff <= crc_n[15:8];
						if (tx_last) begin
							state_ff <= ST_IDLE;
							crc_ff   <= CRC_INIT;
						end
					end
				end
			endcase
		end
	end

	// Parameter space and volatile command registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < PARAM_COUNT; i++) param_ff[i] <= 16'h0000;
			main_cmd_ff <= 9'h000;
			freq_ff     <= 16'h0000;
			vin_lo_ff   <= 8'h00;
			vin_hi_ff   <= 16'h0000;
			dout_ff     <= 16'h0000;
			aout_ff     <= 16'h0000;
		end else begin
			if (wr_en) begin
				if (rd_addr <= PARAM_LAST) param_ff[rd_addr[7:0]] <= wr_data;
				else begin
					case (rd_addr)
						MAIN_CMD: main_cmd_ff <= wr_data[8:0];
						FREQ_REF: freq_ff     <= wr_data;
						VIN_LO:   vin_lo_ff   <= wr_data[15:8];
						VIN_HI:   vin_hi_ff   <= wr_data;
						DOUT:     dout_ff     <= wr_data;
						AOUT:     aout_ff     <= wr_data;
						default: ;
					endcase
				end
			end
			if (coil_en) main_cmd_ff[start_ff[2:0]] <= (cnt_w == COIL_ON);
		end
	end

	// Non-volatile store request for parameter writes only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_wr_ff   <= 1'b0;
			nv_idx_ff  <= 8'h00;
			nv_data_ff <= 16'h0000;
		end else begin
			nv_wr_ff   <= wr_en && (rd_addr <= PARAM_LAST);
			nv_idx_ff  <= rd_addr[7:0];
			nv_data_ff <= wr_data;
		end
	end

	// Drive-facing outputs
	assign cmd_src_comm             = (param_ff[PAR_CMD_SRC] == SRC_COMM);
	assign command_coils            = cmd_src_comm ? main_cmd_ff[7:0] : 8'h00;
	assign run_command              = command_coils[0];
	assign virtual_inputs_enabled   = main_cmd_ff[VIN_EN_BIT];
	assign comm_frequency_reference = freq_ff;
	assign freq_ref_from_comm       = (param_ff[PAR_FREQ_SRC] == SRC_COMM);
	assign virtual_inputs_low       = {vin_lo_ff, main_cmd_ff[7:0]};
	assign virtual_inputs_high      = vin_hi_ff;
	assign changeover_relay_output  = dout_ff[RELAY_DOUT_BIT];
	assign analog_output_terminal   = aout_ff;
	assign param_nv_write           = nv_wr_ff;
	assign param_nv_index           = nv_idx_ff;
	assign param_nv_data            = nv_data_ff;

	a_nv_params: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && rd_addr <= PARAM_LAST |=> param_nv_write && param_nv_data == $past(wr_data))
		else $error("parameter write did not request a store");
	a_freq_volatile: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && rd_addr == FREQ_REF |=> !param_nv_write &&
		comm_frequency_reference == $past(wr_data))
		else $error("frequency write misbehaved");
	a_run_gate: assert property (@(posedge clk) disable iff (!rst_n)
		run_command |-> param_ff[PAR_CMD_SRC] == SRC_COMM)
		else $error("run without serial command source");
	a_coil_run: assert property (@(posedge clk) disable iff (!rst_n)
		coil_en && start_ff == COIL_FIRST && cnt_w == COIL_ON && cmd_src_comm |=> run_command)
		else $error("run coil not taken");
	a_vin_low: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && rd_addr == VIN_LO |=> virtual_inputs_low[15:8] == $past(wr_data[15:8]) &&
		virtual_inputs_low[7:0] == $past(main_cmd_ff[7:0]))
		else $error("virtual input low word wrong");
	a_relay_drive: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && rd_addr == DOUT |=> changeover_relay_output == $past(wr_data[RELAY_DOUT_BIT]))
		else $error("relay output not updated");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_EXEC && buf_ff[1] == FC_RD_HOLD && rd_addr >= RSV_FIRST &&
		rd_addr <= RSV_LAST |-> rd_data == 16'h0000)
		else $error("reserved read not zero");
	a_echo_start: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(tx_valid) |-> tx_data == slave_address ##1
		(!tx_valid || $past(tx_ready) || $stable(tx_data)))
		else $error("response does not start with slave address");
	a_bcast_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_CHECK && buf_ff[0] == 8'h00 |=> !tx_valid [*2])
		else $error("broadcast answered");
endmodule

/* dv/mdr_master_model.sv */
// Serial master model: sends request frames and collects the answer
`timescale 1ns/100ps
module mdr_master_model (
	input  wire logic       clk,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            rx_frame_end,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_last,
	output logic            tx_ready
);
	logic [7:0]  req [$];
	logic [7:0]  rsp [$];
	logic [15:0] crc;
	// Idle link at time zero
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_frame_end = 1'b0;
		tx_ready = 1'b0;
	end
	// Frame check over a byte queue
	function automatic logic [15:0] crc16(input logic [7:0] q [$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	// Send req with its check, then take the answer; bad spoils the check
	task automatic run(input bit slow, input bit bad);
		int n;
		crc = crc16(req) ^ {15'h0000, bad};
		req.push_back(crc[7:0]); // Low byte first
		req.push_back(crc[15:8]);
		rsp.delete();
		foreach (req[i]) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = req[i];
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_frame_end = 1'b1;
		@(negedge clk);
		rx_frame_end = 1'b0;
		// Stalls two cycles of three when slow
		for (n = 0; n < 300; n++) begin
			@(negedge clk);
			rx_data = ~rx_data; // Released line keeps changing
			tx_ready = !slow || (n % 3 == 0);
			if (tx_valid && tx_ready) begin
				rsp.push_back(tx_data);
				if (tx_last)
					break;
			end
		end
		req.delete();
	endtask
endmodule

/* dv/mdr_register_map_bench.sv */
// Self-checking bench for the serial register map
`timescale 1ns/100ps
module mdr_register_map_bench;
	import mdr_pkg::*;
	logic        clk, rst_n, rx_valid, rx_frame_end, tx_valid, tx_ready, tx_last;
	logic [7:0]  rx_data, tx_data, command_coils, param_nv_index;
	logic [15:0] meas_word [12];
	logic [2:0]  fault_kind;
	logic [1:0]  fault_suffix;
	logic [5:0]  discrete_inputs_one_to_six;
	logic [15:0] status_coils, virtual_outputs_low, virtual_outputs_high;
	logic [15:0] analog_input_one_value, analog_input_two_value, pulse_input_value;
	logic        relay_state, run_command, virtual_inputs_enabled, freq_ref_from_comm;
	logic        changeover_relay_output, param_nv_write;
	logic [15:0] comm_frequency_reference, virtual_inputs_low, virtual_inputs_high;
	logic [15:0] analog_output_terminal, param_nv_data;
	logic [15:0] w [$];
	int          bad_count = 0;
	int          checked = 0;
	int          nv_cnt = 0;
	logic [15:0] nv_seen = 16'h0000;
	int          bases [7] = '{64, 80, 88, 92, 96, 100, 104};

	mdr_register_map i_dut (.clk, .rst_n, .slave_address(8'h01), .rx_data, .rx_valid,
		.rx_frame_end, .tx_data, .tx_valid, .tx_ready, .tx_last, .meas_word, .fault_kind,
		.fault_suffix, .discrete_inputs_one_to_six, .status_coils, .relay_state,
		.virtual_outputs_low, .virtual_outputs_high, .analog_input_one_value,
		.analog_input_two_value, .pulse_input_value, .command_coils, .run_command,
		.virtual_inputs_enabled, .comm_frequency_reference, .freq_ref_from_comm,
		.virtual_inputs_low, .virtual_inputs_high, .changeover_relay_output,
		.analog_output_terminal, .param_nv_write, .param_nv_index, .param_nv_data);
	mdr_master_model i_m (.clk, .rx_data, .rx_valid, .rx_frame_end, .tx_data, .tx_valid,
		.tx_last, .tx_ready);

	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Count parameter store pulses, keep index and low data byte of the last one
	always @(posedge clk) begin
		if (param_nv_write === 1'b1) begin
			nv_cnt++;
			nv_seen = {param_nv_index, param_nv_data[7:0]};
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Answer payload, length and check bytes
	task automatic cmp(input logic [7:0] e [$]);
		check(16'(i_m.rsp.size()), 16'(e.size() + 2));
		foreach (e[i])
			check({8'h00, i_m.rsp[i]}, {8'h00, e[i]});
		check(i_m.crc16(i_m.rsp), 16'h0000);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_m.req = '{8'h01, FC_WR_ONE, a[15:8], a[7:0], d[15:8], d[7:0]};
		i_m.run(1'b0, 1'b0);
		cmp('{8'h01, FC_WR_ONE, a[15:8], a[7:0], d[15:8], d[7:0]});
	endtask
	task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] x [$]);
		logic [7:0] e [$];
		e = '{8'h01, fc, 8'(2 * x.size())};
		foreach (x[i]) begin
			e.push_back(x[i][15:8]);
			e.push_back(x[i][7:0]);
		end
		i_m.req = '{8'h01, fc, a[15:8], a[7:0], 8'h00, 8'(x.size())};
		i_m.run(1'b1, 1'b0);
		cmp(e);
	endtask
	task automatic exc(input logic [7:0] q [$], input logic [7:0] code);
		i_m.req = q;
		i_m.run(1'b0, 1'b0);
		cmp('{8'h01, q[1] | EXC_FLAG, code});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog, far beyond the expected run
	initial begin
		#2000000;
		bad_count++;
		summarize();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		foreach (meas_word[i])
			meas_word[i] = 16'h1100 + 16'(i);
		fault_kind = 3'h3;
		fault_suffix = 2'h2;
		discrete_inputs_one_to_six = 6'h2d;
		status_coils = 16'ha55a;
		relay_state = 1'b1;
		virtual_outputs_low = 16'h1357;
		virtual_outputs_high = 16'h2468;
		analog_input_one_value = 16'h2710;
		analog_input_two_value = 16'h1388;
		pulse_input_value = 16'h0321;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check({15'h0000, tx_valid}, 16'h0000);
		check({7'h00, run_command, command_coils}, 16'h0000);
		$display("test reset done");
		// Frequency write touches volatile storage only
		wr(FREQ_REF, 16'h0bb8);
		check({i_m.rsp[6], i_m.rsp[7]}, 16'hdef0);
		check(comm_frequency_reference, 16'h0bb8);
		check({15'h0000, freq_ref_from_comm}, 16'h0000);
		check(16'(nv_cnt), 16'h0000);
		wr(MAIN_CMD, 16'h0001);
		check({15'h0000, run_command}, 16'h0000);
		wr(16'h0001, SRC_COMM);
		check(nv_seen, 16'h0102);
		check({7'h00, run_command, command_coils}, 16'h0101);
		wr(16'h0002, SRC_COMM);
		check({15'h0000, freq_ref_from_comm}, 16'h0001);
		wr(16'h0003, 16'h0bb8);
		check(16'(nv_cnt), 16'h0003);
		rd(FC_RD_HOLD, 16'h0001, '{16'h0002, 16'h0002, 16'h0bb8});
		$display("test parameters done");
		// Virtual input enable, then run by coil
		wr(MAIN_CMD, 16'h0100);
		check({14'h0000, virtual_inputs_enabled, run_command}, 16'h0002);
		i_m.req = '{8'h01, FC_WR_COIL, 8'h00, 8'h48, 8'hff, 8'h00};
		i_m.run(1'b0, 1'b0);
		cmp('{8'h01, FC_WR_COIL, 8'h00, 8'h48, 8'hff, 8'h00});
		check({15'h0000, run_command}, 16'h0001);
		i_m.req = '{8'h01, FC_WR_MULTI, 8'h02, 8'h02, 8'h00, 8'h04, 8'h08, 8'hff, 8'hff,
			8'h5a, 8'ha5, 8'h00, 8'h08, 8'h12, 8'h34};
		i_m.run(1'b0, 1'b0);
		cmp('{8'h01, FC_WR_MULTI, 8'h02, 8'h02, 8'h00, 8'h04});
		check(virtual_inputs_low, 16'hff01);
		check(virtual_inputs_high, 16'h5aa5);
		check({15'h0000, changeover_relay_output}, 16'h0001);
		check(analog_output_terminal, 16'h1234);
		check(16'(nv_cnt), 16'h0003);
		rd(FC_RD_HOLD, MAIN_CMD, '{16'h0101, 16'h0bb8, 16'hff01, 16'h5aa5});
		$display("test commands done");
		// State words, measurements and their mirror
		rd(FC_RD_HOLD, STATUS, '{16'ha55a, 16'h082d, 16'h1357, 16'h2468});
		for (int i = 0; i < 14; i++)
			w.push_back(i < 10 ? meas_word[i] : i == 10 ? 16'd90 : i == 13 ? 16'h002d :
				meas_word[i - 1]);
		rd(FC_RD_IN, 16'h0000, w);
		rd(FC_RD_HOLD, MIRROR_FIRST, w);
		for (int k = 1; k < 8; k++) begin
			fault_kind = 3'(k);
			fault_suffix = 2'(k);
			rd(FC_RD_IN, 16'h000a, '{16'(bases[k - 1] + k % 4)});
		end
		rd(FC_RD_HOLD, AIN_ONE, '{16'h2710, 16'h1388, 16'h0321});
		$display("test reads done");
		// Reserved place, refusals and a spoiled check
		i_m.req = '{8'h01, FC_WR_ONE, 8'h02, 8'h06, 8'hbe, 8'hef};
		i_m.run(1'b0, 1'b0);
		cmp('{8'h01, FC_WR_ONE, 8'h02, 8'h06, 8'hbe, 8'hef});
		rd(FC_RD_HOLD, AOUT, '{16'h1234, 16'h0000});
		exc('{8'h01, FC_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h00}, EX_VALUE);
		exc('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, EX_FUNC);
		exc('{8'h01, FC_RD_HOLD, 8'h01, 8'h00, 8'h00, 8'h01}, EX_ADDR);
		i_m.req = '{8'h01, FC_WR_ONE, 8'h02, 8'h05, 8'h99, 8'h99};
		i_m.run(1'b0, 1'b1);
		check(16'(i_m.rsp.size()), 16'h0000);
		check(analog_output_terminal, 16'h1234);
		// Broadcast write executes without an answer
		i_m.req = '{8'h00, FC_WR_ONE, 8'h02, 8'h05, 8'h43, 8'h21};
		i_m.run(1'b0, 1'b0);
		check(16'(i_m.rsp.size()), 16'h0000);
		check(analog_output_terminal, 16'h4321);
		$display("test refusals done");
		summarize();
	end
endmodule
